// ---- shared/iosr_pkg.sv ----
package iosr_pkg;

    // Unit population and numbering
    localparam int        NUNITS     = 4;
    localparam logic [7:0] DEV_BASE  = 8'h10;

    // Register byte offsets
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_XCTL   = 8'h10;
    localparam logic [7:0] OFF_XDAT   = 8'h14;
    localparam logic [7:0] OFF_XGO    = 8'h18;
    localparam logic [7:0] OFF_XSTAT  = 8'h1C;

    // Field positions
    localparam int CMD_OP_LSB    = 8;
    localparam int RES_OC_LSB    = 16;
    localparam int CTRL_TEST     = 0;
    localparam int CTRL_OFFLINE  = 1;
    localparam int CTRL_IRQ_LSB  = 4;
    localparam int CTRL_UNAV_LSB = 8;
    localparam int STAT_PEND_LSB = 4;
    localparam int STAT_UNUS_LSB = 8;
    localparam int STAT_XBUSY    = 12;
    localparam int XSTAT_ST_LSB  = 16;
    localparam int XSTAT_BUSY    = 18;
    localparam int XGO_WRITE     = 0;
    localparam int XGO_READ      = 1;

    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Response codes {overflow, carry}
    localparam logic [1:0] OC_OK    = 2'h0;
    localparam logic [1:0] OC_REFU  = 2'h1;
    localparam logic [1:0] OC_BUSYX = 2'h2;
    localparam logic [1:0] OC_NONE  = 2'h3;

    // Condition encodings (device and controller alike)
    localparam logic [1:0] COND_READY = 2'h0;
    localparam logic [1:0] COND_NOOP  = 2'h1;
    localparam logic [1:0] COND_UNAV  = 2'h2;
    localparam logic [1:0] COND_BUSY  = 2'h3;

    // Pin synchroniser width
    localparam int SYNC_W = 5 * NUNITS + 19;

    typedef enum logic [2:0] {
        IOSR_START = 3'h0,
        IOSR_TEST  = 3'h1,
        IOSR_TDEV  = 3'h2,
        IOSR_HALT  = 3'h3,
        IOSR_ACK   = 3'h4,
        IOSR_RESET = 3'h5
    } iosr_op_e;

    typedef enum logic [1:0] {
        XD_IDLE = 2'h0,
        XD_HOLD = 2'h1,
        XD_DONE = 2'h3
    } iosr_xd_e;

    typedef struct packed {
        logic [1:0]  oc;
        logic [15:0] acc;
    } iosr_res_s;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] ctrl;
        logic [15:0] data;
        logic        data_oe;
    } iosr_xdio_s;

endpackage

// ---- core/iosr_top.sv ----
// The APB interface to the registers and the address map were chosen for this implementation.
module iosr_top
    import iosr_pkg::*;
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [iosr_pkg::NUNITS-1:0] unit_done,
    input  wire logic [iosr_pkg::NUNITS-1:0] unit_unusual,
    input  wire logic [iosr_pkg::NUNITS-1:0] unit_chain,
    input  wire logic [iosr_pkg::NUNITS-1:0] unit_not_oper,
    input  wire logic [iosr_pkg::NUNITS-1:0] unit_auto,
    output logic      [iosr_pkg::NUNITS-1:0] unit_run,
    input  wire logic                       xdio_ack,
    input  wire logic [1:0]                 xdio_status,
    input  wire logic [15:0]                xdio_data_i,
    output iosr_pkg::iosr_xdio_s            xdio_out
);
    import iosr_pkg::*;

    localparam int N = NUNITS;

    // Pin synchroniser: three stages, filtered value moves when stages 2 and 3 agree
    logic [SYNC_W-1:0] s1, s2, s3, filt, next_filt;
    logic [SYNC_W-1:0] pins;

    assign pins = {unit_done, unit_unusual, unit_chain, unit_not_oper, unit_auto,
                   xdio_ack, xdio_status, xdio_data_i};

    always_comb begin
        next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            filt <= '0;
        end else begin
            s1   <= pins;
            s2   <= s1;
            s3   <= s2;
            filt <= next_filt;
        end
    end

    logic [N-1:0] done_f, unus_f, chain_f, noop_f, auto_f;
    logic         ack_f;
    logic [1:0]   xst_f;
    logic [15:0]  xdat_f;

    assign {done_f, unus_f, chain_f, noop_f, auto_f, ack_f, xst_f, xdat_f} = filt;

    // APB slave: one wait state so every output comes from a flop
    logic        wr_fire;
    logic        next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic        mapped;

    assign wr_fire = psel & penable & pready & pwrite;

    // Control and unit state
    logic [31:0]     ctrl, next_ctrl;
    logic [N-1:0]    busy, next_busy;
    logic [N-1:0]    pend, next_pend;
    logic [N-1:0]    unus, next_unus;
    logic [N-1:0]    done_q, chain_q, next_done_q, next_chain_q;
    logic [N-1:0]    next_run;
    iosr_res_s       result, next_result;
    logic [15:0]     xctl, next_xctl, xdat, next_xdat, xrd, next_xrd;
    logic [1:0]      xst, next_xst;
    iosr_xd_e        xstate, next_xstate;
    iosr_xdio_s      next_xdio;

    logic            test_mode, ctl_off;
    logic [N-1:0]    irq_en, unav;

    assign test_mode = ctrl[CTRL_TEST];
    assign ctl_off   = ctrl[CTRL_OFFLINE];
    assign irq_en    = ctrl[CTRL_IRQ_LSB +: N];
    assign unav      = ctrl[CTRL_UNAV_LSB +: N];

    // Status byte per unit, doc bit 0 at byte MSB
    logic [1:0] ctl_cond;
    logic [7:0] stat_b [N];

    always_comb begin
        if (|busy) begin
            ctl_cond = COND_BUSY;
        end else if (ctl_off) begin
            ctl_cond = COND_NOOP;
        end else begin
            ctl_cond = COND_READY;
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : g_stat
            logic [1:0] dcond;
            always_comb begin
                if (noop_f[g]) begin
                    dcond = COND_NOOP;
                end else if (unav[g]) begin
                    dcond = COND_UNAV;
                end else if (busy[g]) begin
                    dcond = COND_BUSY;
                end else begin
                    dcond = COND_READY;
                end
            end
            // Bit 0 pending, 1-2 device, 3 mode, 4 unusual, 5-6 controller, 7 zero
            assign stat_b[g] = {pend[g], dcond, auto_f[g], unus[g], ctl_cond, 1'b0};
        end
    endgenerate

    // Command decode: match, start acceptance and acknowledge priority
    logic           cmd_fire;
    logic [2:0]     op;
    logic [7:0]     dev;
    logic           hit;
    int             hidx;
    logic           any_pend;
    int             pidx;
    logic           elsewhere;
    logic           can_start;

    assign cmd_fire = wr_fire & (paddr == OFF_CMD);
    assign op       = pwdata[CMD_OP_LSB +: 3];
    assign dev      = pwdata[7:0];

    always_comb begin
        hit      = 1'b0;
        hidx     = 0;
        any_pend = 1'b0;
        pidx     = 0;
        for (int i = 0; i < N; i++) begin
            if (dev == DEV_BASE + 8'(i)) begin
                hit  = 1'b1;
                hidx = i;
            end
        end
        // Lowest unit index has highest priority
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                any_pend = 1'b1;
                pidx     = i;
            end
        end
    end

    // Controller serves one unit at a time; another unit busy blocks status
    assign elsewhere = hit & (|(busy & ~(N'(1) << hidx)));
    assign can_start = hit && !pend[hidx] && !noop_f[hidx] && !unav[hidx]
                       && !busy[hidx] && ctl_cond == COND_READY;

    // Next state for units, result and control
    always_comb begin
        next_busy    = busy;
        next_pend    = pend;
        next_unus    = unus;
        next_result  = result;
        next_ctrl    = ctrl;
        next_done_q  = done_f;
        next_chain_q = chain_f;
        // Keep number bits, status bits zero unless a unit answers; an acknowledge with nothing pending zeroes both
        if (cmd_fire) begin
            next_result.acc = {8'h00, dev};
            next_result.oc  = OC_NONE;
            case (op)
                IOSR_START, IOSR_TEST: begin
                    if (elsewhere) begin
                        next_result.oc = OC_BUSYX;
                    end else if (hit) begin
                        next_result.acc[15:8] = stat_b[hidx];
                        next_result.oc = can_start ? OC_OK : OC_REFU;
                        if (op == IOSR_START && can_start) begin
                            next_busy[hidx] = 1'b1;
                            next_unus[hidx] = 1'b0;
                        end
                    end
                end
                IOSR_TDEV: begin
                    if (elsewhere) begin
                        next_result.oc = OC_BUSYX;
                    end else if (hit) begin
                        next_result.acc[15:8] = stat_b[hidx];
                        next_result.oc = test_mode ? OC_REFU : OC_OK;
                    end
                end
                IOSR_HALT: begin
                    if (elsewhere) begin
                        next_result.oc = OC_BUSYX;
                    end else if (hit) begin
                        next_result.acc[15:8] = stat_b[hidx];
                        next_result.oc = busy[hidx] ? OC_REFU : OC_OK;
                        next_busy[hidx] = 1'b0;
                        next_pend[hidx] = 1'b0;
                        if (busy[hidx]) begin
                            next_unus[hidx] = 1'b1;
                        end
                    end
                end
                IOSR_ACK: begin
                    if (any_pend) begin
                        next_result.acc = {stat_b[pidx], DEV_BASE + 8'(pidx)};
                        next_result.oc  = (unus[pidx] || test_mode) ? OC_REFU : OC_OK;
                        next_pend[pidx] = 1'b0;
                    end else begin
                        next_result.acc = 16'h0000;
                        next_result.oc  = OC_NONE;
                    end
                end
                IOSR_RESET: begin
                    next_result.oc = OC_OK;
                end
                default: begin
                    next_result.oc = OC_BUSYX;
                end
            endcase
        end
        // Device events; a set here wins over a clear in the same cycle, except the reset instruction's clear below
        for (int i = 0; i < N; i++) begin
            if (done_f[i] && !done_q[i] && busy[i]) begin
                next_busy[i] = 1'b0;
                next_unus[i] = unus_f[i];
                if (irq_en[i]) begin
                    next_pend[i] = 1'b1;
                end
            end
            if (chain_f[i] && !chain_q[i] && busy[i] && irq_en[i]) begin
                next_pend[i] = 1'b1;
            end
        end
        if (wr_fire && paddr == OFF_CTRL) begin
            next_ctrl = pwdata;
        end
        // Reset instruction returns every unit and the interrupt state to idle
        if (cmd_fire && op == IOSR_RESET) begin
            next_busy = '0;
            next_pend = '0;
            next_unus = '0;
        end
        // Manual-mode unit holds its accepted start until automatic
        next_run = next_busy & auto_f;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy     <= '0;
            pend     <= '0;
            unus     <= '0;
            done_q   <= '0;
            chain_q  <= '0;
            unit_run <= '0;
            result   <= '0;
            ctrl     <= CTRL_RESET;
        end else begin
            busy     <= next_busy;
            pend     <= next_pend;
            unus     <= next_unus;
            done_q   <= next_done_q;
            chain_q  <= next_chain_q;
            unit_run <= next_run;
            result   <= next_result;
            ctrl     <= next_ctrl;
        end
    end

    // External direct-I/O handshake: lines held from request until acknowledge
    logic xgo_wr, xgo_rd, xreset;

    assign xgo_wr = wr_fire && paddr == OFF_XGO && pwdata[XGO_WRITE];
    assign xgo_rd = wr_fire && paddr == OFF_XGO && pwdata[XGO_READ];
    assign xreset = cmd_fire && op == IOSR_RESET;

    always_comb begin
        next_xstate = xstate;
        next_xdio   = xdio_out;
        next_xctl   = xctl;
        next_xdat   = xdat;
        next_xrd    = xrd;
        next_xst    = xst;
        // Staging registers ignored mid-transfer so lines stay stable
        if (wr_fire && paddr == OFF_XCTL && xstate == XD_IDLE) begin
            next_xctl = pwdata[15:0];
        end
        if (wr_fire && paddr == OFF_XDAT && xstate == XD_IDLE) begin
            next_xdat = pwdata[15:0];
        end
        case (xstate)
            XD_IDLE: begin
                if ((xgo_wr || xgo_rd) && !ack_f) begin
                    next_xstate       = XD_HOLD;
                    next_xdio.req     = 1'b1;
                    next_xdio.wr      = xgo_wr;
                    next_xdio.ctrl    = xctl;
                    next_xdio.data    = xgo_wr ? xdat : 16'h0000;
                    next_xdio.data_oe = xgo_wr;
                end
            end
            XD_HOLD: begin
                if (ack_f) begin
                    next_xst          = xst_f;
                    next_xrd          = xdio_out.wr ? xrd : xdat_f;
                    next_xstate       = XD_DONE;
                    next_xdio.req     = 1'b0;
                    next_xdio.data_oe = 1'b0;
                end
            end
            XD_DONE: begin
                // Wait for the acknowledge to drop before a new transfer
                if (!ack_f) begin
                    next_xstate = XD_IDLE;
                end
            end
            default: begin
                next_xstate = XD_IDLE;
            end
        endcase
        if (xreset) begin
            next_xstate = XD_IDLE;
            next_xdio   = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xstate   <= XD_IDLE;
            xdio_out <= '0;
            xctl     <= '0;
            xdat     <= '0;
            xrd      <= '0;
            xst      <= '0;
        end else begin
            xstate   <= next_xstate;
            xdio_out <= next_xdio;
            xctl     <= next_xctl;
            xdat     <= next_xdat;
            xrd      <= next_xrd;
            xst      <= next_xst;
        end
    end

    // Read mux and handshake; unmapped addresses answer with an error
    always_comb begin
        mapped      = 1'b1;
        next_prdata = 32'h0000_0000;
        if (paddr == OFF_CMD) begin
            next_prdata = 32'h0000_0000;
        end else if (paddr == OFF_RESULT) begin
            next_prdata[17:0] = {result.oc, result.acc};
        end else if (paddr == OFF_CTRL) begin
            next_prdata = ctrl;
        end else if (paddr == OFF_STATUS) begin
            next_prdata[N-1:0]                 = busy;
            next_prdata[STAT_PEND_LSB +: N]    = pend;
            next_prdata[STAT_UNUS_LSB +: N]    = unus;
            next_prdata[STAT_XBUSY]            = (xstate != XD_IDLE);
        end else if (paddr == OFF_XCTL) begin
            next_prdata[15:0] = xctl;
        end else if (paddr == OFF_XDAT) begin
            next_prdata[15:0] = xdat;
        end else if (paddr == OFF_XGO) begin
            next_prdata = 32'h0000_0000;
        end else if (paddr == OFF_XSTAT) begin
            next_prdata[15:0]               = xrd;
            next_prdata[XSTAT_ST_LSB +: 2]  = xst;
            next_prdata[XSTAT_BUSY]         = (xstate != XD_IDLE);
        end else begin
            mapped = 1'b0;
        end
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped;
        if (!(psel && penable && !pready) || pwrite) begin
            next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ---- tb/iosr_top_props.sv ----
module iosr_top_props
    import iosr_pkg::*;
(
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [7:0]                   paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic [iosr_pkg::NUNITS-1:0]  unit_auto,
    input wire logic [iosr_pkg::NUNITS-1:0]  unit_run,
    input wire logic                         xdio_ack,
    input wire iosr_pkg::iosr_xdio_s         xdio_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Go command taken once the acknowledge has been low long enough to pass the filter
    sequence s_xgo_wr;
        (!xdio_ack) [*6] ##0 (psel && penable && pready && pwrite && paddr == OFF_XGO
            && pwdata[XGO_WRITE] && !xdio_out.req);
    endsequence
    sequence s_ack_seen;
        xdio_out.req && $rose(xdio_ack);
    endsequence

    property p_xgo_req;
        s_xgo_wr |=> xdio_out.req && xdio_out.wr && xdio_out.data_oe;
    endproperty
    property p_hold;
        xdio_out.req && !xdio_ack |=>
            xdio_out.req && $stable(xdio_out.ctrl) && $stable(xdio_out.data);
    endproperty
    property p_oe;
        xdio_out.data_oe |-> xdio_out.req && xdio_out.wr;
    endproperty
    property p_rd_lines;
        xdio_out.req && !xdio_out.wr |-> !xdio_out.data_oe && xdio_out.data == 16'h0000;
    endproperty
    property p_release;
        s_ack_seen |-> ##[1:10] !xdio_out.req;
    endproperty
    property p_reset_quiet;
        $rose(presetn) |-> !pready && unit_run == '0 && !xdio_out.req;
    endproperty
    // Unit 2 is the one the bench parks in manual mode
    property p_manual;
        (!unit_auto[2]) [*8] |-> !unit_run[2];
    endproperty
    property p_quiet;
        !pready |-> prdata == 32'h0000_0000;
    endproperty

    a_xgo_req: assert property (p_xgo_req) else $error("external request not raised");
    a_hold: assert property (p_hold) else $error("external lines moved before ack");
    a_oe: assert property (p_oe) else $error("data driven outside a write");
    a_rd_lines: assert property (p_rd_lines) else $error("read drives data lines");
    a_release: assert property (p_release) else $error("request not released after ack");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_manual: assert property (p_manual) else $error("manual unit operating");
    a_quiet: assert property (p_quiet) else $error("read data outside answer");
endmodule
bind iosr_top iosr_top_props i_iosr_top_props (.*);

// ---- tb/iosr_xdio_model.sv ----
module iosr_xdio_model
    import iosr_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire iosr_pkg::iosr_xdio_s xdio_out,
    input  wire logic [3:0]           delay,
    input  wire logic [15:0]          rd_word,
    input  wire logic [1:0]           rd_stat,
    output logic                      xdio_ack,
    output logic [1:0]                xdio_status,
    output logic [15:0]               xdio_data_i,
    output logic [31:0]               got
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;

    // Answer after a chosen delay; released lines toggle so stale data never passes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xdio_ack <= 1'b0;
            cnt <= 4'h0;
            xdio_status <= 2'h0;
            xdio_data_i <= 16'h0000;
            got <= 32'h0000_0000;
        end else begin
            if (!xdio_ack) begin
                xdio_data_i <= ~xdio_data_i;
                xdio_status <= ~xdio_status;
            end
            if (xdio_out.req && !xdio_ack && cnt == delay) begin
                xdio_ack <= 1'b1;
                xdio_data_i <= rd_word;
                xdio_status <= rd_stat;
                got <= {xdio_out.ctrl, xdio_out.data};
            end else if (xdio_out.req && !xdio_ack) begin
                cnt <= cnt + 4'h1;
            end else if (xdio_ack && !xdio_out.req) begin
                xdio_ack <= 1'b0;
                cnt <= 4'h0;
            end
        end
    end
endmodule

// ---- tb/iosr_top_test.sv ----
module iosr_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import iosr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, got;
    logic [NUNITS-1:0] unit_done = 0, unit_unusual = 0, unit_chain = 0, unit_not_oper = 0;
    logic [NUNITS-1:0] unit_auto = 4'hF, unit_run;
    logic xdio_ack;
    logic [1:0] xdio_status, rd_stat = 0;
    logic [15:0] xdio_data_i, rd_word = 0;
    logic [3:0] delay = 0;
    iosr_xdio_s xdio_out;
    int error_cnt = 0, n_tests = 0;

    iosr_top i_iosr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unit_done(unit_done), .unit_unusual(unit_unusual),
        .unit_chain(unit_chain), .unit_not_oper(unit_not_oper), .unit_auto(unit_auto),
        .unit_run(unit_run), .xdio_ack(xdio_ack), .xdio_status(xdio_status),
        .xdio_data_i(xdio_data_i), .xdio_out(xdio_out));
    iosr_xdio_model i_iosr_xdio_model (.pclk(pclk), .presetn(presetn), .xdio_out(xdio_out),
        .delay(delay), .rd_word(rd_word), .rd_stat(rd_stat), .xdio_ack(xdio_ack),
        .xdio_status(xdio_status), .xdio_data_i(xdio_data_i), .got(got));

    always #2.5 pclk = ~pclk;

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reads right after the edge see pre-edge values, so pready is sampled race-free
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        if (n >= 50) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [7:0] dev, output logic [31:0] q);
        apb(1'b1, OFF_CMD, {21'h0, op, dev}, q);
        apb(1'b0, OFF_RESULT, 32'h0, q);
    endtask
    task automatic xwait(output logic [31:0] q);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_XSTAT, 32'h0, q);
            n++;
        end while (q[XSTAT_BUSY] !== 1'b0 && n < 40);
    endtask
    function automatic logic [7:0] sb(logic p, logic [1:0] d, logic a, logic u, logic [1:0] c);
        return {p, d, a, u, c, 1'b0};
    endfunction
    function automatic logic [31:0] rs(logic [1:0] oc, logic [7:0] s, logic [7:0] n);
        return {14'h0, oc, s, n};
    endfunction

    task automatic t_idle;
        logic [31:0] q;
        cmd(IOSR_TEST, 8'h20, q);
        chk("test unmatched", q, rs(OC_NONE, 8'h00, 8'h20));
        cmd(IOSR_TEST, DEV_BASE, q);
        chk("test idle", q, rs(OC_OK, sb(0, COND_READY, 1, 0, COND_READY), DEV_BASE));
        apb(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
        $display("idle test done");
    endtask
    task automatic t_irq;
        logic [31:0] q;
        apb(1'b1, OFF_CTRL, 32'h0000_0010, q);
        cmd(IOSR_START, DEV_BASE, q);
        chk("start code", {q[17:16], q[7:0]}, {22'h0, OC_OK, DEV_BASE});
        tick(8);
        chk("run", unit_run, 4'h1);
        cmd(IOSR_TEST, DEV_BASE, q);
        chk("test busy", q, rs(OC_REFU, sb(0, COND_BUSY, 1, 0, COND_BUSY), DEV_BASE));
        cmd(IOSR_START, DEV_BASE + 8'h1, q);
        chk("busy other", q, rs(OC_BUSYX, 8'h00, DEV_BASE + 8'h1));
        unit_unusual <= 4'h1;
        unit_done <= 4'h1;
        tick(8);
        unit_done <= 4'h0;
        tick(8);
        apb(1'b0, OFF_STATUS, 32'h0, q);
        chk("status", q, 32'h0000_0110);
        cmd(IOSR_START, DEV_BASE, q);
        chk("start pend", q, rs(OC_REFU, sb(1, COND_READY, 1, 1, COND_READY), DEV_BASE));
        cmd(IOSR_ACK, 8'h00, q);
        chk("ack", {q[17:16], q[7:0]}, {22'h0, OC_REFU, DEV_BASE});
        cmd(IOSR_ACK, 8'h00, q);
        chk("ack none", q, rs(OC_NONE, 8'h00, 8'h00));
        unit_unusual <= 4'h0;
        $display("interrupt test done");
    endtask
    task automatic t_halt;
        logic [31:0] q;
        unit_auto <= 4'hB;
        tick(8);
        cmd(IOSR_START, DEV_BASE + 8'h2, q);
        chk("start manual", q[17:16], OC_OK);
        tick(8);
        chk("manual idle", unit_run, 4'h0);
        cmd(IOSR_HALT, DEV_BASE + 8'h2, q);
        chk("halt busy", q[17:16], OC_REFU);
        cmd(IOSR_TEST, DEV_BASE + 8'h2, q);
        chk("halted", q, rs(OC_OK, sb(0, COND_READY, 0, 1, COND_READY), DEV_BASE + 8'h2));
        cmd(IOSR_HALT, DEV_BASE + 8'h2, q);
        chk("halt idle", q[17:16], OC_OK);
        unit_auto <= 4'hF;
        $display("halt test done");
    endtask
    task automatic t_modes;
        logic [31:0] q;
        unit_not_oper <= 4'h8;
        tick(8);
        cmd(IOSR_START, DEV_BASE + 8'h3, q);
        chk("inop", q, rs(OC_REFU, sb(0, COND_NOOP, 1, 0, COND_READY), DEV_BASE + 8'h3));
        unit_not_oper <= 4'h0;
        apb(1'b1, OFF_CTRL, 32'h0000_0001, q);
        cmd(IOSR_TDEV, DEV_BASE, q);
        chk("tdev test mode", q[17:16], OC_REFU);
        apb(1'b1, OFF_CTRL, 32'h0, q);
        cmd(IOSR_TDEV, DEV_BASE, q);
        chk("tdev", q[17:16], OC_OK);
        cmd(IOSR_TDEV, 8'h30, q);
        chk("tdev none", q[17:16], OC_NONE);
        cmd(3'h6, 8'h00, q);
        chk("invalid", q[17:16], OC_BUSYX);
        apb(1'b1, OFF_CTRL, 32'h0000_0010, q);
        cmd(IOSR_START, DEV_BASE, q);
        unit_chain <= 4'h1;
        tick(8);
        apb(1'b0, OFF_STATUS, 32'h0, q);
        chk("chain pend", q, 32'h0000_0411);
        unit_chain <= 4'h0;
        cmd(IOSR_RESET, 8'h00, q);
        apb(1'b0, OFF_STATUS, 32'h0, q);
        chk("after reset io", q, 32'h0);
        chk("run stopped", unit_run, 4'h0);
        $display("modes test done");
    endtask
    task automatic t_ext;
        logic [31:0] q;
        apb(1'b1, OFF_XCTL, 32'h0000_A5C3, q);
        apb(1'b1, OFF_XDAT, 32'h0000_1234, q);
        rd_stat <= 2'h1;
        apb(1'b1, OFF_XGO, 32'h1, q);
        xwait(q);
        chk("ext write lines", got, 32'hA5C3_1234);
        chk("ext write stat", q[17:16], 2'h1);
        delay <= 4'h9;
        rd_word <= 16'hBEEF;
        rd_stat <= 2'h2;
        apb(1'b1, OFF_XGO, 32'h2, q);
        xwait(q);
        chk("ext read", q, 32'h0002_BEEF);
        $display("external test done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence after two cycles of reset
    initial begin
        tick(2);
        presetn <= 1'b1;
        tick(1);
        t_idle;
        t_irq;
        t_halt;
        t_modes;
        t_ext;
        wrap_up;
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #50us;
        error_cnt++;
        wrap_up;
    end
endmodule
